/* mrs_cfg.svh */
// Constants for the room status responder
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH

// ****************************************************************
// Function and exception codes
// ****************************************************************
`define MRS_FC_READ_HOLD   8'h03
`define MRS_FC_READ_INPUT  8'h04
`define MRS_EXC_FLAG       8'h80
`define MRS_EXC_ILL_FUNC   8'h01
`define MRS_EXC_ILL_ADDR   8'h02
`define MRS_EXC_ILL_VALUE  8'h03

// ****************************************************************
// Register map
// ****************************************************************
`define MRS_ERR_ADDR       16'h0000
`define MRS_ROOM_FIRST     16'h0001
`define MRS_ROOM_LAST      16'h05dc
`define MRS_QTY_MAX        16'h007d
`define MRS_ROOM_RST       1'b0
`define MRS_COMM_ERR_RST   1'b1

// ****************************************************************
// Link settings
// ****************************************************************
`define MRS_TCP_PORT_DFLT  16'h01f6
`define MRS_SLAVE_ID_DFLT  8'h01

`endif

/* mrs_pkg.sv */
// Types shared by the room status responder
package mrs_pkg;

    // Decoded read request handed over by the frame layer
    typedef struct packed {
        logic [7:0]  unitId;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] qty;
    } mrs_req_t;

    // One byte of an outgoing stream
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } mrs_byte_t;

    // Room state update from the hotel system side
    typedef struct packed {
        logic [15:0] room;
        logic        checkedIn;
    } mrs_room_evt_t;

    // Responder states
    typedef enum logic [2:0] {
        MRS_IDLE  = 3'b000,
        MRS_FUNC  = 3'b001,
        MRS_CNT   = 3'b010,
        MRS_HI    = 3'b011,
        MRS_LO    = 3'b100,
        MRS_XCODE = 3'b101
    } mrs_state_t;

endpackage

/* mrs_ident.sv */
// Identification text streamer for the configuration serial port
`timescale 1ns/10ps
`include "mrs_cfg.svh"

module mrs_ident
    import mrs_pkg::*;
#(
    parameter int               IDENT_LEN  = 16,
    // Text is arbitrary; first character in the top byte
    parameter logic [8*16-1:0]  IDENT_TEXT = "ROOMSTAT SLAVE\r\n"
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Query from the console receiver
    input  wire logic       identQuery,
    // Text stream to the console transmitter
    output mrs_byte_t       conByte,
    output logic            conValid,
    input  wire logic       conReady
);

    logic [7:0]  idx_ff;
    logic        busy_ff;
    mrs_byte_t   conByte_ff;

    // ************************************************************
    // Text sequencing
    // ************************************************************

    // Walk the text one byte per accepted handshake
    always_ff @(posedge core_clk) begin
        if (rst) begin
            idx_ff     <= 8'h00;
            busy_ff    <= 1'b0;
            conByte_ff <= '0;
        end else if (!busy_ff && identQuery) begin
            busy_ff         <= 1'b1;
            idx_ff          <= 8'h01;
            conByte_ff.data <= IDENT_TEXT[8*IDENT_LEN-1 -: 8];
            conByte_ff.last <= (IDENT_LEN == 1);
        end else if (busy_ff && conReady) begin
            if (conByte_ff.last) begin
                busy_ff <= 1'b0;
            end else begin
                idx_ff          <= idx_ff + 8'h01;
                conByte_ff.data <=
                    IDENT_TEXT[8*(IDENT_LEN-32'(idx_ff))-1 -: 8];
                conByte_ff.last <= (32'(idx_ff) == IDENT_LEN-1);
            end
        end
    end

    assign conValid = busy_ff;
    assign conByte  = conByte_ff;

endmodule

/* mrs_room_slave.sv */
// Modbus room status slave: register store, read responder, console
`timescale 1ns/10ps
`include "mrs_cfg.svh"


module mrs_room_slave
    import mrs_pkg::*;
#(
    parameter logic [15:0] TCP_PORT  = `MRS_TCP_PORT_DFLT,
    parameter logic [7:0]  SLAVE_ID  = `MRS_SLAVE_ID_DFLT,
    parameter int          IDENT_LEN = 16
) (
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // Transport selection
    input  wire logic      modeTcp,
    output logic [15:0]    tcpListenPort,
    // Request from the frame layer
    input  mrs_req_t       req,
    input  wire logic      reqValid,
    output logic           reqReady,
    // Response PDU byte stream
    output mrs_byte_t      rsp,
    output logic           rspValid,
    input  wire logic      rspReady,
    // Hotel system side
    input  mrs_room_evt_t  roomEvt,
    input  wire logic      roomEvtValid,
    input  wire logic      hmsExchangeOk,
    input  wire logic      hmsLinkFail,
    output logic           commError,
    // Configuration serial port
    input  wire logic      identQuery,
    output mrs_byte_t      conByte,
    output logic           conValid,
    input  wire logic      conReady
);

    // ************************************************************
    // Storage
    // ************************************************************

    logic [`MRS_ROOM_LAST:`MRS_ROOM_FIRST] roomBits_ff;
    logic        commErr_ff;

    mrs_state_t  state_ff;
    mrs_state_t  nxt_state;
    mrs_byte_t   rsp_ff;
    mrs_byte_t   nxt_rsp;
    logic [7:0]  excCode_ff;
    logic [7:0]  nxt_excCode;
    logic        isExc_ff;
    logic        nxt_isExc;
    logic [15:0] curAddr_ff;
    logic [15:0] nxt_curAddr;
    logic [7:0]  remain_ff;
    logic [7:0]  nxt_remain;

    logic        accept;
    logic        takeByte;
    logic        forUs;
    logic        funcOk;
    logic        qtyOk;
    logic [16:0] endAddr;
    logic        rangeOk;
    logic        wordBit;

    // One store element per room, written by matching events
    genvar gi;
    generate
        for (gi = `MRS_ROOM_FIRST; gi <= `MRS_ROOM_LAST; gi++) begin : g_room
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    roomBits_ff[gi] <= `MRS_ROOM_RST;
                end else if (roomEvtValid && roomEvt.room == 16'(gi)) begin
                    roomBits_ff[gi] <= roomEvt.checkedIn;
                end
            end
        end
    endgenerate

    // Link health: a failure wins over a good exchange in one cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            commErr_ff <= `MRS_COMM_ERR_RST;
        end else if (hmsLinkFail) begin
            commErr_ff <= 1'b1;
        end else if (hmsExchangeOk) begin
            commErr_ff <= 1'b0;
        end
    end

    assign commError     = commErr_ff;
    assign tcpListenPort = TCP_PORT;

    // ************************************************************
    // Request decode
    // ************************************************************

    // Only reads are served; everything else is an exception
    assign funcOk  = (req.func == `MRS_FC_READ_HOLD) ||
                     (req.func == `MRS_FC_READ_INPUT);
    assign qtyOk   = (req.qty != 16'h0000) && (req.qty <= `MRS_QTY_MAX);
    assign endAddr = {1'b0, req.addr} + {1'b0, req.qty} - 17'h00001;
    assign rangeOk = (endAddr <= {1'b0, `MRS_ROOM_LAST});
    // RTU frames for another slave are dropped silently
    assign forUs   = modeTcp || (req.unitId == SLAVE_ID);

    assign reqReady = (state_ff == MRS_IDLE);
    assign accept   = reqValid && reqReady;
    assign rspValid = (state_ff != MRS_IDLE);
    assign rsp      = rsp_ff;
    assign takeByte = rspValid && rspReady;

    // Address 0 is the error register, 1 to 1500 are rooms, higher addresses read 0
    always_comb begin
        if (curAddr_ff == `MRS_ERR_ADDR) begin
            wordBit = commErr_ff;
        end else if (curAddr_ff <= `MRS_ROOM_LAST) begin
            wordBit = roomBits_ff[curAddr_ff[10:0]];
        end else begin
            wordBit = 1'b0;
        end
    end

    // ************************************************************
    // Response sequencing
    // ************************************************************

    // Next byte and state for the response stream
    always_comb begin
        nxt_state   = state_ff;
        nxt_rsp     = rsp_ff;
        nxt_excCode = excCode_ff;
        nxt_isExc   = isExc_ff;
        nxt_curAddr = curAddr_ff;
        nxt_remain  = remain_ff;
        case (state_ff)
            MRS_IDLE: begin
                if (accept && forUs) begin
                    nxt_state   = MRS_FUNC;
                    nxt_curAddr = req.addr;
                    nxt_remain  = req.qty[7:0];
                    nxt_rsp.last = 1'b0;
                    if (!funcOk) begin
                        nxt_isExc   = 1'b1;
                        nxt_excCode = `MRS_EXC_ILL_FUNC;
                    end else if (!qtyOk) begin
                        nxt_isExc   = 1'b1;
                        nxt_excCode = `MRS_EXC_ILL_VALUE;
                    end else if (!rangeOk) begin
                        nxt_isExc   = 1'b1;
                        nxt_excCode = `MRS_EXC_ILL_ADDR;
                    end else begin
                        nxt_isExc   = 1'b0;
                        nxt_excCode = 8'h00;
                    end
                    nxt_rsp.data = (funcOk && qtyOk && rangeOk) ?
                                   req.func : (req.func | `MRS_EXC_FLAG);
                end
            end
            MRS_FUNC: begin
                if (takeByte) begin
                    if (isExc_ff) begin
                        nxt_state = MRS_XCODE;
                        nxt_rsp   = '{last: 1'b1, data: excCode_ff};
                    end else begin
                        nxt_state = MRS_CNT;
                        nxt_rsp   = '{last: 1'b0, data: {remain_ff[6:0], 1'b0}};
                    end
                end
            end
            MRS_CNT: begin
                if (takeByte) begin
                    nxt_state = MRS_HI;
                    nxt_rsp   = '{last: 1'b0, data: 8'h00};
                end
            end
            MRS_HI: begin
                if (takeByte) begin
                    nxt_state = MRS_LO;
                    nxt_rsp   = '{last: (remain_ff == 8'h01),
                                  data: {7'h00, wordBit}};
                end
            end
            MRS_LO: begin
                if (takeByte) begin
                    if (remain_ff == 8'h01) begin
                        nxt_state = MRS_IDLE;
                    end else begin
                        nxt_state   = MRS_HI;
                        nxt_remain  = remain_ff - 8'h01;
                        nxt_curAddr = curAddr_ff + 16'h0001;
                        nxt_rsp     = '{last: 1'b0, data: 8'h00};
                    end
                end
            end
            MRS_XCODE: begin
                if (takeByte) begin
                    nxt_state = MRS_IDLE;
                end
            end
            default: begin
                nxt_state = MRS_IDLE;
            end
        endcase
    end

    // Responder state registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff   <= MRS_IDLE;
            rsp_ff     <= '0;
            excCode_ff <= 8'h00;
            isExc_ff   <= 1'b0;
            curAddr_ff <= 16'h0000;
            remain_ff  <= 8'h00;
        end else begin
            state_ff   <= nxt_state;
            rsp_ff     <= nxt_rsp;
            excCode_ff <= nxt_excCode;
            isExc_ff   <= nxt_isExc;
            curAddr_ff <= nxt_curAddr;
            remain_ff  <= nxt_remain;
        end
    end

    // ************************************************************
    // Configuration console
    // ************************************************************

    // Answers identification queries with the ident text
    mrs_ident #(
        .IDENT_LEN (IDENT_LEN)
    ) u_ident (
        .core_clk   (core_clk),
        .rst        (rst),
        .identQuery (identQuery),
        .conByte    (conByte),
        .conValid   (conValid),
        .conReady   (conReady)
    );

endmodule

/* mrs_room_slave_sva.sv */
// Port assertions for the room status slave
`timescale 1ns/10ps
module mrs_room_slave_sva
    import mrs_pkg::*;
#(
    parameter logic [15:0] TCP_PORT = 16'h01f6,
    parameter logic [7:0]  SLAVE_ID = 8'h01
) (
    // Clock, reset, mode
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        modeTcp,
    input  wire logic [15:0] tcpListenPort,
    // Request and response
    input  mrs_req_t         req,
    input  wire logic        reqValid,
    input  wire logic        reqReady,
    input  mrs_byte_t        rsp,
    input  wire logic        rspValid,
    input  wire logic        rspReady,
    // Hotel link and console
    input  wire logic        hmsExchangeOk,
    input  wire logic        hmsLinkFail,
    input  wire logic        commError,
    input  wire logic        identQuery,
    input  wire logic        conValid
);
    logic take;
    logic okFc;
    logic okRd;

    // Request accepted and addressed to this slave
    assign take = reqValid && reqReady && (modeTcp || req.unitId == SLAVE_ID);
    assign okFc = req.func == 8'h03 || req.func == 8'h04;
    // A read is served only with a legal count inside the register map
    assign okRd = okFc && req.qty != 16'h0000 && req.qty <= 16'h007d &&
                  {1'b0, req.addr} + {1'b0, req.qty} <= 17'h005dd;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    a_answer_next: assert property (take |=> rspValid)
        else $error("no response byte after request");
    a_other_unit: assert property (reqValid && reqReady && !modeTcp
        && req.unitId != SLAVE_ID |=> !rspValid)
        else $error("reply to foreign unit id");
    a_first_byte: assert property (take |=> rsp.data == ($past(okRd) ?
        $past(req.func) : ($past(req.func) | 8'h80)))
        else $error("wrong function byte");
    a_busy_refuse: assert property (rspValid && !(rspReady && rsp.last)
        |=> rspValid && !reqReady)
        else $error("response dropped or request accepted while busy");
    a_byte_holds: assert property (rspValid && !rspReady
        |=> rspValid && $stable(rsp))
        else $error("response byte changed while stalled");
    a_last_ends: assert property (rspValid && rspReady && rsp.last
        |=> !rspValid)
        else $error("bytes after last");
    a_link_fail: assert property (hmsLinkFail |=> commError)
        else $error("link failure not flagged");
    a_link_ok: assert property (hmsExchangeOk && !hmsLinkFail
        |=> !commError)
        else $error("good exchange not cleared");
    a_tcp_port: assert property (tcpListenPort == TCP_PORT)
        else $error("listen port differs");
    a_ident_start: assert property (identQuery && !conValid |=> conValid)
        else $error("no ident text after query");
    a_rst_values: assert property ($fell(rst)
        |-> commError && !rspValid && !conValid)
        else $error("bad values after reset");

    c_bad_func: cover property (take && !okFc);
    c_long_read: cover property (take && req.qty == 16'h007d);
    c_ident: cover property (identQuery && !conValid);
endmodule

bind mrs_room_slave mrs_room_slave_sva #(
    .TCP_PORT(TCP_PORT), .SLAVE_ID(SLAVE_ID)
) sva_u (
    .core_clk, .rst, .modeTcp, .tcpListenPort, .req, .reqValid, .reqReady,
    .rsp, .rspValid, .rspReady, .hmsExchangeOk, .hmsLinkFail, .commError,
    .identQuery, .conValid
);

/* mrs_master_model.sv */
// Master side model: drains response and console byte streams
`timescale 1ns/10ps
module mrs_master_model
    import mrs_pkg::*;
(
    // Clock, reset and stall mode
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic slow,
    // Response stream
    input  mrs_byte_t rsp,
    input  wire logic rspValid,
    output logic      rspReady,
    // Console stream
    input  mrs_byte_t conByte,
    input  wire logic conValid,
    output logic      conReady
);
    logic [8:0] rxq[$];
    logic [8:0] conq[$];

    // Ready after the first edge, random stalls when slow
    always @(posedge core_clk) begin
        rspReady <= !slow || ($urandom % 3 == 0);
        conReady <= !slow || 1'($urandom);
    end

    // Keep accepted bytes in arrival order
    always @(posedge core_clk) begin
        if (!rst && rspValid && rspReady) begin
            rxq.push_back(rsp);
        end
        if (!rst && conValid && conReady) begin
            conq.push_back(conByte);
        end
    end
endmodule

/* mrs_room_slave_bench.sv */
// Self-checking bench for the room status slave
`timescale 1ns/10ps
module mrs_room_slave_bench
    import mrs_pkg::*;
;
    localparam logic [7:0] SID = 8'h01;
    localparam logic [127:0] IDENT = "ROOMSTAT SLAVE\r\n";
    logic          core_clk = 1'b0;
    logic          rst = 1'b1;
    logic          modeTcp = 1'b1;
    logic          reqValid = 1'b0;
    logic          roomEvtValid = 1'b0;
    logic          hmsExchangeOk = 1'b0;
    logic          hmsLinkFail = 1'b0;
    logic          identQuery = 1'b0;
    logic          slow = 1'b0;
    mrs_req_t      req = '0;
    mrs_room_evt_t roomEvt = '0;
    logic          reqReady, rspValid, rspReady, commError, conValid, conReady;
    logic [15:0]   tcpListenPort;
    mrs_byte_t     rsp, conByte;
    logic          mirror [0:1500];
    logic [8:0]    expq[$];
    logic [7:0]    fcs [5] = '{8'h03, 8'h04, 8'h06, 8'h10, 8'h01};
    logic [15:0]   edgeRooms [4] = '{16'h0001, 16'h05dc, 16'h0000, 16'h05dd};
    int            err_total = 0;
    int            checks_done = 0;
    int            cyc = 0;
    int            evCnt = 0;

    mrs_room_slave dut_u (
        .core_clk(core_clk), .rst(rst), .modeTcp(modeTcp),
        .tcpListenPort(tcpListenPort), .req(req), .reqValid(reqValid),
        .reqReady(reqReady), .rsp(rsp), .rspValid(rspValid),
        .rspReady(rspReady), .roomEvt(roomEvt), .roomEvtValid(roomEvtValid),
        .hmsExchangeOk(hmsExchangeOk), .hmsLinkFail(hmsLinkFail),
        .commError(commError), .identQuery(identQuery), .conByte(conByte),
        .conValid(conValid), .conReady(conReady)
    );
    mrs_master_model mst_u (
        .core_clk(core_clk), .rst(rst), .slow(slow), .rsp(rsp),
        .rspValid(rspValid), .rspReady(rspReady), .conByte(conByte),
        .conValid(conValid), .conReady(conReady)
    );

    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            complete_run;
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Expected reply bytes from the mirrored register contents
    function automatic void exp_rsp(input logic [7:0] fc, input int a, q);
        logic [7:0] code;
        code = (fc != 8'h03 && fc != 8'h04) ? 8'h01 :
               (q == 0 || q > 125) ? 8'h03 : (a + q > 1501) ? 8'h02 : 8'h00;
        expq = '{{1'b0, fc | 8'h80}, {1'b1, code}};
        if (code == 8'h00) begin
            expq = '{{1'b0, fc}, {1'b0, 8'(2 * q)}};
            for (int i = 0; i < q; i++) begin
                expq.push_back(9'h000);
                expq.push_back({i == q - 1, 7'h00, mirror[a + i]});
            end
        end
    endfunction

    // One request, then wait for and compare the whole reply
    task automatic poll(input logic [7:0] fc, input int a, q,
                        input logic tcp, input logic [7:0] uid);
        int n;
        modeTcp <= tcp;
        req <= '{uid, fc, 16'(a), 16'(q)};
        reqValid <= 1'b1;
        // Hold the request until the responder is seen idle at an edge
        do begin
            @(posedge core_clk);
        end while (!reqReady);
        reqValid <= 1'b0;
        expq.delete();
        if (tcp || uid == SID) exp_rsp(fc, a, q);
        for (n = 0; n < 1000 && mst_u.rxq.size() < expq.size(); n++)
            @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        chk("rsp count", 16'(mst_u.rxq.size()), 16'(expq.size()));
        for (n = 0; n < expq.size(); n++)
            chk("rsp byte", mst_u.rxq[n], expq[n]);
        mst_u.rxq.delete();
    endtask

    // Back-to-back room events, edge rooms first
    task automatic events(input int n);
        logic [15:0] r;
        logic v;
        for (int i = 0; i < n; i++) begin
            r = evCnt < 4 ? edgeRooms[evCnt] : 16'($urandom_range(1500, 1));
            v = 1'($urandom);
            evCnt++;
            roomEvt <= '{r, v};
            roomEvtValid <= 1'b1;
            if (r >= 1 && r <= 1500) mirror[r] = v;
            @(posedge core_clk);
        end
        roomEvtValid <= 1'b0;
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'h5e35a25f));
        foreach (mirror[k]) mirror[k] = 1'b0;
        mirror[0] = 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("commError", commError, 16'h0001);
        chk("tcp port", tcpListenPort, 16'h01f6);
        poll(8'h04, 0, 2, 1'b1, 8'h07);
        poll(8'h03, 1499, 2, 1'b0, SID);
        events(12);
        hmsExchangeOk <= 1'b1;
        mirror[0] = 1'b0;
        @(posedge core_clk);
        hmsExchangeOk <= 1'b0;
        poll(8'h03, 0, 125, 1'b1, SID);
        poll(8'h04, 1, 126, 1'b1, SID);
        poll(8'h04, 1500, 1, 1'b0, SID);
        poll(8'h04, 1500, 2, 1'b0, SID);
        poll(8'h03, 5, 0, 1'b1, SID);
        poll(8'h03, 5, 1, 1'b0, 8'h02);
        for (int i = 0; i < 40; i++) begin
            if (i % 8 == 0) events(6);
            slow <= 1'($urandom);
            poll(fcs[$urandom % 5], $urandom_range(1505, 0),
                 $urandom_range(9, 0), 1'($urandom),
                 ($urandom % 4 == 0) ? 8'h02 : SID);
        end
        hmsExchangeOk <= 1'b1;
        hmsLinkFail <= 1'b1;
        mirror[0] = 1'b1;
        @(posedge core_clk);
        hmsExchangeOk <= 1'b0;
        hmsLinkFail <= 1'b0;
        poll(8'h04, 0, 1, 1'b1, SID);
        identQuery <= 1'b1;
        @(posedge core_clk);
        identQuery <= 1'b0;
        for (int i = 0; i < 300 && mst_u.conq.size() < 16; i++)
            @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        chk("con count", 16'(mst_u.conq.size()), 16'h0010);
        for (int i = 0; i < mst_u.conq.size(); i++)
            chk("con byte", mst_u.conq[i],
                {i == 15, IDENT[8*(15-i) +: 8]});
        complete_run;
    end
endmodule
